/* rtl/blpwm_top.sv */
// Backlight PWM control: duty combination, dimming, pin drive and readback.
// Assumes control inputs come from the command decoder on the same clock;
// the sleep flag, ADC samples and the host lux value are also synchronous.
//
// Summary of operation
// - Output brightness is light or manual ratio times content-adaptive ratio.
// - Gate off holds PWM pin static off, level set by pin polarity.
// - Gate on drives PWM waveform, true or inverted by polarity bit.
// - Enable pin equals invert bit when gate is zero; else source, maybe inverted.
// - Control off dims backlight down; readback becomes 00h after dimming.
// - Control on keeps backlight on; readback shows combined result.
// - Lux sensing and auto select on yield first averaged ambient value within 500 ms.
// - Sleep-in disables converter and brightness control regardless of bits.
// - Sleep-out without lux or auto uses manual brightness, converter off.
// - Lux and auto with converter off use host-written ambient level.
// - Lux, auto and converter on enable 10-bit converter, automatic control.
// - Auto select zero means manual brightness; automatic only when set.
// - Content-adaptive off reads FFh unless forced; brightness from manual or light value.
// - Content modes read their duty, floored at the minimum; manual or light value times that ratio.
// - Light readback is manual value unless auto and lux both set.
// - Light path removes mains flicker and applies hysteresis.
// - Sensed ambient light is readable by the host.
// - PWM clock 5 MHz when select is zero; period 256 times divider.
// - One dimming bit enables dimming of both adaptive paths.
// - Sleep-in makes functions unavailable and backlight off.
`timescale 1ns/1ps
`include "blpwm_consts.svh"
module blpwm_top
    import blpwm_pkg::*;
#(
    parameter int unsigned FIRST_AVG_CYC = `BLPWM_FIRST_AVG_CYC,
    parameter int unsigned FLICKER_CYC   = `BLPWM_FLICKER_CYC,
    parameter int unsigned DIM_STEP_CYC  = `BLPWM_DIM_STEP_CYC
) (
    // Clock and reset
    input  wire logic           clock_in,
    input  wire logic           rst_n_in,
    // Host control bits and values
    input  wire blpwm_ctrl_s    ctrl_in,
    input  wire blpwm_ca_mode_e ca_mode_in,
    input  wire logic [7:0]     brightness_value_in,
    input  wire logic [7:0]     forced_duty_in,
    input  wire logic [7:0]     min_brightness_in,
    input  wire logic [7:0]     pwm_divider_in,
    input  wire logic [15:0]    ambient_level_field_in,
    input  wire logic [9:0]     hysteresis_in,
    // Chip state and content-adaptive engine
    input  wire logic           sleep_out_in,
    input  wire logic [7:0]     content_duty_in,
    // Internal converter
    input  wire logic           adc_valid_in,
    input  wire logic [9:0]     adc_data_in,
    output logic                adc_enable_out,
    // Pins toward the LED driver
    output logic                backlight_pwm_pin_out,
    output logic                backlight_enable_pin_out,
    // Readback
    output blpwm_status_s       status_out
);
    // ============================================================
    // Types and state
    typedef struct packed {
        logic [31:0]   fosc_cnt;
        logic [7:0]    div_cnt;
        logic [7:0]    pwm_cnt;
        logic [7:0]    cur_duty;
        logic [31:0]   dim_cnt;
        logic [31:0]   avg_cnt;
        logic          pwm_pin;
        logic          en_pin;
        logic          adc_en;
        blpwm_status_s status;
    } blpwm_st_s;

    blpwm_st_s  st_q;
    blpwm_st_s  st_d;
    blpwm_src_e src;
    logic [7:0] light_duty;
    logic [7:0] content_duty;
    logic [7:0] target;
    logic [7:0] combined;
    logic [7:0] ca_raw;
    logic [9:0] lux_level;
    logic       lux_valid;
    logic       filt_en;
    logic       host_lux_valid;
    logic [9:0] filt_sample;
    logic       fosc_tick;
    logic       pwm_tick;
    logic       raw_pwm;
    logic       lux_mode_q;
    logic [31:0] fosc_div;

    // Product of two ratios in 8-bit duty units, FFh meaning 100 percent.
    function automatic logic [7:0] blpwm_mul(input logic [7:0] a, input logic [7:0] b);
        logic [15:0] p;
        p = {8'h00, a} * {8'h00, b};
        return 8'((p + 16'h00FF) >> 8);
    endfunction

    // Larger of two duties.
    function automatic logic [7:0] blpwm_max(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction

    // ============================================================
    // Brightness source selection
    // Sleep-in overrides every enable bit.
    always_comb begin
        if (!sleep_out_in) begin
            src = BLPWM_SRC_OFF;
        end else if (!(ctrl_in.lux_sense_on && ctrl_in.auto_brightness_sel)) begin
            src = BLPWM_SRC_MANUAL;
        end else if (!ctrl_in.internal_adc_on) begin
            src = BLPWM_SRC_HOST_LUX;
        end else begin
            src = BLPWM_SRC_ADC_LUX;
        end
    end

    // Light path input: converter samples or host-written ambient level.
    assign filt_en        = (src == BLPWM_SRC_HOST_LUX) || (src == BLPWM_SRC_ADC_LUX);
    assign host_lux_valid = (src == BLPWM_SRC_HOST_LUX);
    assign filt_sample    = (src == BLPWM_SRC_ADC_LUX) ? adc_data_in
                            : ambient_level_field_in[15:6];

    blpwm_lux_filter #(
        .WIN_CYC (FLICKER_CYC)
    ) u_lux (
        .clock_in        (clock_in),
        .rst_n_in        (rst_n_in),
        .enable_in       (filt_en),
        .hysteresis_in   (hysteresis_in),
        .sample_valid_in ((src == BLPWM_SRC_ADC_LUX) ? adc_valid_in : host_lux_valid),
        .sample_in       (filt_sample),
        .level_out       (lux_level),
        .level_valid_out (lux_valid)
    );

    // Light or manual duty, and content-adaptive duty.
    always_comb begin
        if (filt_en) begin
            light_duty = lux_level[9:2];
        end else begin
            light_duty = brightness_value_in;
        end
        ca_raw = ctrl_in.force_content_duty ? forced_duty_in : content_duty_in;
        if (ca_mode_in == BLPWM_CA_OFF && !ctrl_in.force_content_duty) begin
            content_duty = `BLPWM_DUTY_FULL;
        end else begin
            content_duty = blpwm_max(ca_raw, min_brightness_in);
        end
        combined = blpwm_mul(light_duty, content_duty);
        if (src == BLPWM_SRC_OFF || !ctrl_in.backlight_ctrl_on) begin
            target = `BLPWM_DUTY_ZERO;
        end else begin
            target = combined;
        end
    end

    // ============================================================
    // PWM clock and counter
    assign fosc_div  = ctrl_in.pwm_clock_sel ? 32'(`BLPWM_FOSC_FAST_DIV)
                       : 32'(`BLPWM_FOSC_SLOW_DIV);
    assign fosc_tick = (st_q.fosc_cnt >= fosc_div - 32'd1);
    assign pwm_tick  = fosc_tick && (st_q.div_cnt + 8'h01 >= pwm_divider_in);
    // Duty FFh keeps the compare true over the whole period.
    assign raw_pwm   = (st_q.cur_duty == `BLPWM_DUTY_FULL) || (st_q.pwm_cnt < st_q.cur_duty);

    // Next state.
    always_comb begin
        st_d = st_q;
        // Operating clock enable.
        st_d.fosc_cnt = fosc_tick ? 32'd0 : st_q.fosc_cnt + 32'd1;
        if (fosc_tick) begin
            st_d.div_cnt = pwm_tick ? 8'h00 : st_q.div_cnt + 8'h01;
        end
        if (pwm_tick) begin
            st_d.pwm_cnt = st_q.pwm_cnt + 8'h01;
        end
        // Dimming walks one code per step; without it the duty jumps.
        if (src == BLPWM_SRC_OFF) begin
            st_d.cur_duty = `BLPWM_DUTY_ZERO;
            st_d.dim_cnt  = '0;
        end else if (!ctrl_in.dimming_on) begin
            st_d.cur_duty = target;
            st_d.dim_cnt  = '0;
        end else if (st_q.cur_duty != target) begin
            if (st_q.dim_cnt >= DIM_STEP_CYC - 1) begin
                st_d.dim_cnt  = '0;
                st_d.cur_duty = (st_q.cur_duty < target) ? st_q.cur_duty + 8'h01
                                : st_q.cur_duty - 8'h01;
            end else begin
                st_d.dim_cnt = st_q.dim_cnt + 32'd1;
            end
        end else begin
            st_d.dim_cnt = '0;
        end
        // Pin drive.
        if (ctrl_in.backlight_output_gate) begin
            st_d.pwm_pin = raw_pwm ^ ctrl_in.pwm_pin_invert;
            st_d.en_pin  = ctrl_in.enable_pin_source ^ ctrl_in.enable_pin_invert;
        end else begin
            st_d.pwm_pin = ctrl_in.pwm_pin_invert;
            st_d.en_pin  = ctrl_in.enable_pin_invert;
        end
        st_d.adc_en = (src == BLPWM_SRC_ADC_LUX);
        // First averaged value is due within the sampling deadline.
        if (!filt_en || !lux_mode_q) begin
            st_d.avg_cnt = '0;
        end else if (!lux_valid && st_q.avg_cnt < FIRST_AVG_CYC) begin
            st_d.avg_cnt = st_q.avg_cnt + 32'd1;
        end
        // Readback.
        st_d.status.brightness_readback  = st_q.cur_duty;
        st_d.status.content_duty_readback = content_duty;
        st_d.status.light_duty_readback  = light_duty;
        st_d.status.ambient_readback     = lux_level;
        st_d.status.ambient_valid        = lux_valid;
    end

    // State register.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_q       <= '0;
            lux_mode_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            lux_mode_q <= filt_en;
        end
    end

    assign backlight_pwm_pin_out    = st_q.pwm_pin;
    assign backlight_enable_pin_out = st_q.en_pin;
    assign adc_enable_out           = st_q.adc_en;
    assign status_out               = st_q.status;

    // ============================================================
    // Checks
    AST_GATE_OFF_PWM: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !ctrl_in.backlight_output_gate |=> backlight_pwm_pin_out == $past(ctrl_in.pwm_pin_invert))
        else $error("PWM pin not static off while gate is low");
    AST_GATE_ON_PWM: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_in.backlight_output_gate
        |=> backlight_pwm_pin_out == ($past(raw_pwm) ^ $past(ctrl_in.pwm_pin_invert)))
        else $error("PWM pin polarity wrong while gate is high");
    AST_ENABLE_PIN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_in.backlight_output_gate |=> backlight_enable_pin_out ==
        ($past(ctrl_in.enable_pin_source) ^ $past(ctrl_in.enable_pin_invert)))
        else $error("Enable pin does not follow its source");
    AST_ENABLE_OFF_INV: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !ctrl_in.backlight_output_gate && ctrl_in.enable_pin_invert
        |=> backlight_enable_pin_out)
        else $error("Enable pin not high with gate low and invert set");
    AST_SLEEP_ADC_OFF: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !sleep_out_in [*2] |-> !adc_enable_out && st_q.cur_duty == 8'h00)
        else $error("Converter or duty active in sleep-in");
    AST_ADC_ON: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        sleep_out_in && ctrl_in.lux_sense_on && ctrl_in.auto_brightness_sel
        && ctrl_in.internal_adc_on |=> adc_enable_out)
        else $error("Converter not enabled in automatic mode");
    AST_CA_OFF_FF: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ca_mode_in == BLPWM_CA_OFF && !ctrl_in.force_content_duty
        |=> status_out.content_duty_readback == 8'hFF)
        else $error("Content readback not FFh in off mode");
    AST_LIGHT_MANUAL: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !(ctrl_in.lux_sense_on && ctrl_in.auto_brightness_sel)
        |=> status_out.light_duty_readback == $past(brightness_value_in))
        else $error("Light readback not the manual value");
    AST_NO_DIM_JUMP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !ctrl_in.dimming_on && sleep_out_in |=> st_q.cur_duty == $past(target))
        else $error("Duty did not jump with dimming off");
    AST_FIRST_AVG: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_q.avg_cnt < FIRST_AVG_CYC)
        else $error("No averaged ambient value within deadline");
endmodule

/* common/blpwm_consts.svh */
// Timing counts, reset values and fixed duty codes for the backlight PWM block.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef BLPWM_CONSTS_SVH
`define BLPWM_CONSTS_SVH
// ============================================================
// Clock and timing
`define BLPWM_CLK_HZ          20000000
`define BLPWM_FOSC_SLOW_HZ    5000000
`define BLPWM_FOSC_FAST_HZ    10000000
`define BLPWM_FOSC_SLOW_DIV   (`BLPWM_CLK_HZ / `BLPWM_FOSC_SLOW_HZ)
`define BLPWM_FOSC_FAST_DIV   (`BLPWM_CLK_HZ / `BLPWM_FOSC_FAST_HZ)
`define BLPWM_FIRST_AVG_MS    500
`define BLPWM_FIRST_AVG_CYC   ((`BLPWM_CLK_HZ / 1000) * `BLPWM_FIRST_AVG_MS)
`define BLPWM_FLICKER_MS      20
`define BLPWM_FLICKER_CYC     ((`BLPWM_CLK_HZ / 1000) * `BLPWM_FLICKER_MS)
// ============================================================
// Duty codes, reset values and dimming step count
`define BLPWM_DUTY_FULL       8'hFF
`define BLPWM_DUTY_ZERO       8'h00
`define BLPWM_HYST_DEFAULT    10'h010
`define BLPWM_DIM_STEP_CYC    32'd2000
`endif

/* common/blpwm_pkg.sv */
// Types shared by the backlight PWM block.
// Assumes blpwm_consts.svh holds the numeric constants.
package blpwm_pkg;
    // ============================================================
    // Content-adaptive modes
    typedef enum logic [1:0] {
        BLPWM_CA_OFF,
        BLPWM_CA_UI,
        BLPWM_CA_STILL,
        BLPWM_CA_MOVING
    } blpwm_ca_mode_e;

    // Brightness source in effect
    typedef enum logic [1:0] {
        BLPWM_SRC_OFF,
        BLPWM_SRC_MANUAL,
        BLPWM_SRC_HOST_LUX,
        BLPWM_SRC_ADC_LUX
    } blpwm_src_e;

    // Control bits written by the host.
    typedef struct packed {
        logic backlight_output_gate;
        logic pwm_pin_invert;
        logic enable_pin_invert;
        logic enable_pin_source;
        logic backlight_ctrl_on;
        logic auto_brightness_sel;
        logic lux_sense_on;
        logic internal_adc_on;
        logic dimming_on;
        logic pwm_clock_sel;
        logic force_content_duty;
    } blpwm_ctrl_s;

    // Readback values seen by the host.
    typedef struct packed {
        logic [7:0]  brightness_readback;
        logic [7:0]  content_duty_readback;
        logic [7:0]  light_duty_readback;
        logic [9:0]  ambient_readback;
        logic        ambient_valid;
    } blpwm_status_s;
endpackage

/* rtl/blpwm_lux_filter.sv */
// Ambient light path: flicker averaging and hysteresis on 10-bit samples.
// Assumes samples arrive as a one-cycle strobe on the system clock.
`timescale 1ns/1ps
`include "blpwm_consts.svh"
module blpwm_lux_filter
    import blpwm_pkg::*;
#(
    parameter int unsigned WIN_CYC = `BLPWM_FLICKER_CYC
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Control
    input  wire logic       enable_in,
    input  wire logic [9:0] hysteresis_in,
    // Samples
    input  wire logic       sample_valid_in,
    input  wire logic [9:0] sample_in,
    // Filtered result
    output logic [9:0]      level_out,
    output logic            level_valid_out
);
    // ============================================================
    // State
    typedef struct packed {
        logic [31:0] win_cnt;
        logic [25:0] acc;
        logic [15:0] n;
        logic [9:0]  level;
        logic        valid;
    } blpwm_lf_s;

    blpwm_lf_s st_q;
    blpwm_lf_s st_d;
    logic [9:0] avg;
    logic [9:0] diff;

    // Averaging over a window covering whole mains cycles removes flicker.
    always_comb begin
        st_d = st_q;
        avg  = (st_q.n == 16'h0000) ? st_q.level
               : 10'(st_q.acc / {10'h000, st_q.n});
        diff = (avg > st_q.level) ? (avg - st_q.level) : (st_q.level - avg);
        if (!enable_in) begin
            st_d = '0;
        end else begin
            if (sample_valid_in) begin
                st_d.acc = st_q.acc + {16'h0000, sample_in};
                st_d.n   = st_q.n + 16'h0001;
            end
            if (st_q.win_cnt >= WIN_CYC - 1) begin
                st_d.win_cnt = '0;
                st_d.acc     = '0;
                st_d.n       = '0;
                // Hysteresis holds the level against small swings.
                if (!st_q.valid || diff > hysteresis_in) begin
                    st_d.level = avg;
                end
                st_d.valid = 1'b1;
            end else begin
                st_d.win_cnt = st_q.win_cnt + 32'd1;
            end
        end
    end

    // State register.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out       = st_q.level;
    assign level_valid_out = st_q.valid;
endmodule

/* bench/blpwm_led_drv.sv */
// Stand-in for the external LED driver: counts cycles in which the LEDs are lit.
// Assumes both pins are registered on the same system clock as the block.
`timescale 1ns/1ps
// ============================================================
// LED driver model
module blpwm_led_drv (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Pins from the block and count control
    input  wire logic        pwm_pin_in,
    input  wire logic        enable_pin_in,
    input  wire logic        clear_in,
    // Lit cycle count
    output logic [15:0]      lit_count_out
);
    // The LEDs light only while enabled and the PWM input is high.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || clear_in) begin
            lit_count_out <= 16'h0000;
        end else if (pwm_pin_in && enable_pin_in) begin
            lit_count_out <= lit_count_out + 16'h0001;
        end
    end
endmodule

/* bench/test_blpwm_top.sv */
// Self-checking bench for the backlight PWM block with an LED driver model.
// Assumes the block is parameterised with short counts for simulation.
`timescale 1ns/1ps
// ============================================================
// Bench top
module test_blpwm_top
    import blpwm_pkg::*;
;
    logic           clock_in;
    logic           rst_n_in;
    blpwm_ctrl_s    ctrl;
    blpwm_ca_mode_e ca_mode;
    logic [7:0]     bright;
    logic [7:0]     forced;
    logic [15:0]    amb_field;
    logic           sleep_out;
    logic [7:0]     content;
    logic           adc_valid;
    logic           adc_en;
    logic           pwm_pin;
    logic           en_pin;
    blpwm_status_s  st;
    logic           clear;
    logic [15:0]    lit;
    logic [7:0]     min_bright;
    logic [7:0]     divider;
    logic [9:0]     hyst;
    logic           pwm_prev;
    logic [3:0]     rises;
    int             fail_count;
    int             tests_run;

    blpwm_top #(.FIRST_AVG_CYC(2000), .FLICKER_CYC(100), .DIM_STEP_CYC(4)) i_blpwm_top (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl), .ca_mode_in(ca_mode),
        .brightness_value_in(bright), .forced_duty_in(forced), .min_brightness_in(min_bright),
        .pwm_divider_in(divider), .ambient_level_field_in(amb_field),
        .hysteresis_in(hyst), .sleep_out_in(sleep_out), .content_duty_in(content),
        .adc_valid_in(adc_valid), .adc_data_in(10'h200), .adc_enable_out(adc_en),
        .backlight_pwm_pin_out(pwm_pin), .backlight_enable_pin_out(en_pin),
        .status_out(st));

    blpwm_led_drv i_blpwm_led_drv (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .pwm_pin_in(pwm_pin),
        .enable_pin_in(en_pin), .clear_in(clear), .lit_count_out(lit));

    // The clock runs at 20 MHz.
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // Converter samples arrive every other cycle.
    always @(negedge clock_in) begin
        adc_valid <= !adc_valid;
    end

    // Counts rising edges of the PWM pin so the period length can be judged.
    always @(posedge clock_in) begin
        pwm_prev <= pwm_pin;
        if (clear) begin
            rises <= 4'h0;
        end else if (pwm_pin && !pwm_prev) begin
            rises <= rises + 4'h1;
        end
    end

    // Compares one value and reports a mismatch.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    // Prints the verdict and stops.
    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Gate, polarity and enable source combinations at duty zero.
    task automatic t_pins();
        for (int i = 0; i < 8; i++) begin
            ctrl.backlight_output_gate = i[2];
            ctrl.pwm_pin_invert = i[1];
            ctrl.enable_pin_invert = i[1];
            ctrl.enable_pin_source = i[0];
            step(3);
            check("pwm_pin", 16'(pwm_pin), 16'(i[1]));
            check("en_pin", 16'(en_pin), 16'(i[2] ? i[0] ^ i[1] : i[1]));
        end
    endtask

    // Manual brightness when only one of auto and lux is set.
    task automatic t_manual();
        bright = 8'h5A;
        for (int i = 0; i < 2; i++) begin
            ctrl.lux_sense_on = i[0];
            ctrl.auto_brightness_sel = !i[0];
            step(4);
            check("light_rb", 16'(st.light_duty_readback), 16'h005A);
            check("content_rb", 16'(st.content_duty_readback), 16'h00FF);
            check("bright_rb", 16'(st.brightness_readback), 16'h005A);
        end
        ctrl.lux_sense_on = 1'b0;
        ctrl.auto_brightness_sel = 1'b0;
    endtask

    // Content modes multiply the manual ratio; forcing overrides off mode.
    task automatic t_content();
        bright = 8'h64;
        content = 8'h33;
        for (int m = 1; m < 4; m++) begin
            ca_mode = blpwm_ca_mode_e'(m);
            step(4);
            check("content_rb", 16'(st.content_duty_readback), 16'h0033);
            check("bright_rb", 16'(st.brightness_readback), 16'h0014);
        end
        min_bright = 8'h50;
        step(4);
        check("min_rb", 16'(st.content_duty_readback), 16'h0050);
        check("min_bright_rb", 16'(st.brightness_readback), 16'h0020);
        min_bright = 8'h00;
        ca_mode = BLPWM_CA_OFF;
        ctrl.force_content_duty = 1'b1;
        forced = 8'h40;
        step(4);
        check("forced_rb", 16'(st.content_duty_readback), 16'h0040);
        ctrl.force_content_duty = 1'b0;
    endtask

    // Lit cycles and pin rising edges over a window of 2048 system cycles.
    task automatic measure(input logic [7:0] duty, input logic inv, input logic [15:0] exp,
                           input logic [3:0] exp_r);
        bright = duty;
        ctrl.pwm_pin_invert = inv;
        step(8);
        clear = 1'b1;
        step(1);
        clear = 1'b0;
        step(2048);
        check("lit_count", lit, exp);
        check("pwm_rises", 16'(rises), 16'(exp_r));
    endtask

    task automatic t_pwm();
        ctrl.backlight_output_gate = 1'b1;
        ctrl.enable_pin_invert = 1'b0;
        ctrl.enable_pin_source = 1'b1;
        measure(8'h80, 1'b0, 16'h0400, 4'h2);
        measure(8'hFF, 1'b0, 16'h0800, 4'h0);
        measure(8'h40, 1'b1, 16'h0600, 4'h2);
        // A divider of two stretches the period to the whole window.
        divider = 8'h02;
        measure(8'h80, 1'b0, 16'h0400, 4'h1);
        divider = 8'h01;
        ctrl.pwm_pin_invert = 1'b0;
    endtask

    // Control off walks down 16 codes at 4 cycles each before reading zero.
    task automatic t_dim();
        int n;
        bright = 8'h10;
        step(4);
        ctrl.dimming_on = 1'b1;
        ctrl.backlight_ctrl_on = 1'b0;
        step(3);
        check("dim_busy", 16'(st.brightness_readback != 8'h00), 16'h0001);
        n = 3;
        while (st.brightness_readback !== 8'h00 && n < 300) begin
            step(1);
            n++;
        end
        check("dim_zero", 16'(st.brightness_readback), 16'h0000);
        check("dim_long", 16'(n >= 60), 16'h0001);
        ctrl.backlight_ctrl_on = 1'b1;
        ctrl.dimming_on = 1'b0;
        step(20);
    endtask

    // Host-written ambient level drives the light path.
    task automatic t_lux();
        int n;
        amb_field = 16'hFF00;
        ctrl.lux_sense_on = 1'b1;
        ctrl.auto_brightness_sel = 1'b1;
        n = 0;
        while (st.ambient_valid !== 1'b1 && n < 2010) begin
            step(1);
            n++;
        end
        check("amb_valid", 16'(st.ambient_valid), 16'h0001);
        step(50);
        check("amb_rb", 16'(st.ambient_readback), 16'h03FC);
        check("light_rb", 16'(st.light_duty_readback), 16'h00FF);
        check("bright_rb", 16'(st.brightness_readback), 16'h00FF);
        // A swing below the threshold is held, and passes once the threshold drops.
        amb_field = 16'hFC00;
        step(250);
        check("amb_hold", 16'(st.ambient_readback), 16'h03FC);
        hyst = 10'h008;
        step(250);
        check("amb_move", 16'(st.ambient_readback), 16'h03F0);
        check("light_rb", 16'(st.light_duty_readback), 16'h00FC);
    endtask

    // Converter follows sleep state in full automatic mode.
    task automatic t_sleep();
        ctrl.internal_adc_on = 1'b1;
        step(4);
        check("adc_en", 16'(adc_en), 16'h0001);
        sleep_out = 1'b0;
        step(4);
        check("adc_en", 16'(adc_en), 16'h0000);
        check("bright_rb", 16'(st.brightness_readback), 16'h0000);
    endtask

    // Watchdog well past the expected run of about 9000 cycles.
    initial begin
        repeat (20000) @(negedge clock_in);
        fail_count++;
        end_sim();
    end

    // Main sequence: defaults, 10 cycles of reset, then the scenarios.
    initial begin
        fail_count = 0;
        tests_run = 0;
        rst_n_in = 1'b0;
        ctrl = '0;
        ctrl.backlight_ctrl_on = 1'b1;
        ca_mode = BLPWM_CA_OFF;
        bright = 8'h00;
        forced = 8'h00;
        amb_field = 16'h0000;
        sleep_out = 1'b1;
        content = 8'hFF;
        adc_valid = 1'b0;
        clear = 1'b0;
        min_bright = 8'h00;
        divider = 8'h01;
        hyst = 10'h010;
        step(10);
        rst_n_in = 1'b1;
        step(2);
        t_pins();
        t_manual();
        t_content();
        t_pwm();
        t_dim();
        t_lux();
        t_sleep();
        end_sim();
    end
endmodule
